// ---- logic/blc_cfg.svh ----
// Constants shared by the exclusive-lock bridge end and the initiator end.
// Assumes inclusion by bare name; holds macro definitions only.
`ifndef BLC_CFG_SVH
`define BLC_CFG_SVH
`define BLC_AW 32
`define BLC_CMD_MEM_RD 4'h6
`define BLC_CMD_MEM_WR 4'h7
`define BLC_MTO_CYCLES 32768
`define BLC_HOST_WAIT 8
`define BLC_RES_OK 2'h0
`define BLC_RES_RETRY 2'h1
`define BLC_RES_TABORT 2'h2
`define BLC_RES_MABORT 2'h3
`endif

// ---- logic/blc_pkg.sv ----
// Types for the exclusive-lock bridge pair.
// Assumes blc_cfg.svh is on the include path.
`include "blc_cfg.svh"
package blc_pkg;
  // Cross-bridge lock owner state.
  typedef enum logic [1:0] {LK_IDLE = 2'b00, LK_PEND = 2'b01, LK_EST = 2'b10,
    LK_REL = 2'b11} lock_state_t;
  // Target-bus sequencer state.
  typedef enum logic [1:0] {SQ_IDLE = 2'b00, SQ_REQ = 2'b01, SQ_ADDR = 2'b10,
    SQ_DATA = 2'b11} seq_state_t;
  // Termination kept for a delayed request.
  typedef enum logic [1:0] {AB_NONE = 2'b00, AB_TARGET = 2'b01,
    AB_MASTER = 2'b10} abort_t;
  // Initiator sequencer state.
  typedef enum logic [1:0] {HS_IDLE = 2'b00, HS_CHECK = 2'b01, HS_ADDR = 2'b10,
    HS_DATA = 2'b11} host_state_t;
  // Whole state of the bridge end.
  typedef struct packed {
    lock_state_t st;
    seq_state_t sq;
    logic cand_v;
    logic [3:0] cand_cmd;
    logic [`BLC_AW-1:0] cand_addr;
    logic [3:0] cand_be;
    logic [`BLC_AW-1:0] cand_wdata;
    logic cand_down;
    logic [3:0] q_cmd;
    logic [`BLC_AW-1:0] q_addr;
    logic [3:0] q_be;
    logic [`BLC_AW-1:0] q_wdata;
    logic q_write;
    logic [`BLC_AW-1:0] rdata;
    logic dly_ready;
    abort_t dly_abort;
    logic own_lock;
    logic rel_at_end;
    logic [15:0] tmo;
    logic rsp_trdy;
    logic rsp_retry;
    logic rsp_tabort;
    logic rsp_mabort;
    logic s_start;
    logic serr;
    logic sse;
    logic rta;
    logic rma;
  } bridge_state_t;
  // Whole state of the initiator end.
  typedef struct packed {
    host_state_t st;
    logic frame_n;
    logic lock_n;
    logic addr_valid;
    logic [3:0] cmd;
    logic [`BLC_AW-1:0] addr;
    logic [3:0] be;
    logic [`BLC_AW-1:0] wdata;
    logic down;
    logic is_lock;
    logic is_last;
    logic owned;
    logic [3:0] wait_cnt;
    logic done;
    logic [1:0] result;
    logic [`BLC_AW-1:0] rdata;
  } host_state_regs_t;
endpackage : blc_pkg

// ---- logic/blc_if.sv ----
// Primary-bus view shared by the initiator end and the bridge end.
// Assumes both ends run on the same mclk.
`timescale 1ns/100ps
`default_nettype none
`include "blc_cfg.svh"
interface blc_if;
  logic frame_n; // Frame, active low.
  logic lock_n; // Exclusive lock, active low.
  logic addr_valid; // One-cycle address phase strobe.
  logic [3:0] cmd; // Bus command.
  logic [`BLC_AW-1:0] addr; // Address.
  logic [3:0] be; // Byte enables.
  logic [`BLC_AW-1:0] wdata; // Write data.
  logic downstream; // Target lies beyond the bridge.
  logic trdy; // Data transferred.
  logic retry; // Target retry.
  logic tabort; // Target abort.
  logic mabort; // Master abort.
  logic [`BLC_AW-1:0] rdata; // Read data.
  modport initiator (output frame_n, lock_n, addr_valid, cmd, addr, be, wdata,
    downstream, input trdy, retry, tabort, mabort, rdata);
  modport bridge (input frame_n, lock_n, addr_valid, cmd, addr, be, wdata,
    downstream, output trdy, retry, tabort, mabort, rdata);
endinterface : blc_if
`default_nettype wire

// ---- logic/blc_bridge.sv ----
// Bridge end: exclusive-lock control between primary and target bus.
// Assumes the initiator end on the interface and a target-bus port outside.
`timescale 1ns/100ps
`default_nettype none
`include "blc_cfg.svh"
module blc_bridge #(
  parameter int MTO_CYCLES = `BLC_MTO_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  blc_if.bridge p,
  input wire logic q_empty, // Earlier queued transactions have drained.
  input wire logic s_bus_idle, // Target bus idle.
  input wire logic s_gnt, // Target bus grant.
  input wire logic s_lock_n_i, // Target-bus lock level.
  input wire logic s_done, // Target-bus data transfer done.
  input wire logic s_retry, // Target-bus retry.
  input wire logic s_tabort, // Target-bus target abort.
  input wire logic s_mabort, // Target-bus master abort.
  input wire logic [`BLC_AW-1:0] s_rdata, // Target-bus read data.
  input wire logic serr_enable, // System error enable.
  input wire logic master_abort_mode, // Master abort mode.
  input wire logic mto_serr_enable, // System error on master timeout.
  input wire logic status_clear, // Clears sticky status flags.
  output logic s_req, // Target-bus request.
  output logic s_start, // Target-bus address phase strobe.
  output logic [3:0] s_cmd, // Target-bus command.
  output logic [`BLC_AW-1:0] s_addr, // Target-bus address.
  output logic [3:0] s_be, // Target-bus byte enables.
  output logic [`BLC_AW-1:0] s_wdata, // Target-bus write data.
  output logic s_lock_n_o, // Target-bus lock drive level.
  output logic s_lock_oe_n, // Target-bus lock enable, low drives.
  output logic primary_system_error_n, // System error, active low.
  output logic signaled_system_error, // Sticky signaled flag.
  output logic received_target_abort, // Sticky target abort flag.
  output logic received_master_abort, // Sticky master abort flag.
  output blc_pkg::lock_state_t lock_state // Owner state.
);
  blc_pkg::bridge_state_t r; // Registered state.
  blc_pkg::bridge_state_t next_r; // Next state.
  logic lk; // Candidate carries the lock sequence.
  logic match; // Candidate repeats the queued request.
  logic lock_free; // Target lock not held by another master.

  // Lock sequence seen one cycle after the address phase.
  assign lk = ~p.lock_n;
  assign match = lk && r.cand_cmd == r.q_cmd && r.cand_addr == r.q_addr &&
    r.cand_be == r.q_be;
  assign lock_free = s_lock_n_i || r.own_lock;

  // Next-state logic for the whole bridge end.
  always_comb begin
    logic set_ta;
    logic set_ma;
    set_ta = 1'b0;
    set_ma = 1'b0;
    next_r = r;
    next_r.rsp_trdy = 1'b0;
    next_r.rsp_retry = 1'b0;
    next_r.rsp_tabort = 1'b0;
    next_r.rsp_mabort = 1'b0;
    next_r.s_start = 1'b0;
    next_r.serr = 1'b0;
    // Capture each primary address phase for judging next cycle.
    next_r.cand_v = p.addr_valid;
    if (p.addr_valid) begin
      next_r.cand_cmd = p.cmd;
      next_r.cand_addr = p.addr;
      next_r.cand_be = p.be;
      next_r.cand_wdata = p.wdata;
      next_r.cand_down = p.downstream;
    end
    // Master timeout runs while the opening locked read's data waits for its repeat.
    if (r.st == blc_pkg::LK_PEND && r.dly_ready) begin
      next_r.tmo = r.tmo + 16'h0001;
    end else begin
      next_r.tmo = 16'h0000;
    end
    // Judge the captured primary transaction.
    if (r.cand_v) begin
      if (!r.cand_down) begin
        // Not for the far side: secondary locks never couple in.
      end else if (r.st == blc_pkg::LK_IDLE) begin
        if (!lk) begin
          // Unlocked traffic is forwarded by the ordinary path.
        end else if (r.cand_cmd != `BLC_CMD_MEM_RD) begin
          next_r.rsp_mabort = 1'b1;
        end else if (!s_lock_n_i) begin
          next_r.rsp_retry = 1'b1;
        end else begin
          // Queue the opening locked read as a delayed request.
          next_r.q_cmd = r.cand_cmd;
          next_r.q_addr = r.cand_addr;
          next_r.q_be = r.cand_be;
          next_r.q_write = 1'b0;
          next_r.dly_ready = 1'b0;
          next_r.st = blc_pkg::LK_PEND;
          next_r.sq = blc_pkg::SQ_REQ;
          next_r.rsp_retry = 1'b1;
        end
      end else if (match && r.dly_ready) begin
        // Answer the repeat with what the target bus returned.
        next_r.dly_ready = 1'b0;
        case (r.dly_abort)
          blc_pkg::AB_NONE: begin
            next_r.rsp_trdy = 1'b1;
            if (r.st == blc_pkg::LK_PEND) begin
              next_r.st = blc_pkg::LK_EST;
            end
          end
          blc_pkg::AB_TARGET: begin
            next_r.rsp_tabort = 1'b1;
            set_ta = 1'b1;
          end
          default: begin
            next_r.rsp_mabort = 1'b1;
            set_ma = 1'b1;
          end
        endcase
        if (r.dly_abort != blc_pkg::AB_NONE && r.st == blc_pkg::LK_PEND) begin
          next_r.st = blc_pkg::LK_IDLE;
        end
      end else if (lk && r.st == blc_pkg::LK_EST && !r.dly_ready &&
                   r.sq == blc_pkg::SQ_IDLE) begin
        // Further locked memory reads and writes go out locked; other commands master-abort.
        next_r.q_cmd = r.cand_cmd;
        next_r.q_addr = r.cand_addr;
        next_r.q_be = r.cand_be;
        next_r.q_wdata = r.cand_wdata;
        if (r.cand_cmd == `BLC_CMD_MEM_WR) begin
          next_r.q_write = 1'b1;
          next_r.rsp_trdy = 1'b1;
          next_r.sq = blc_pkg::SQ_REQ;
        end else if (r.cand_cmd == `BLC_CMD_MEM_RD) begin
          next_r.q_write = 1'b0;
          next_r.rsp_retry = 1'b1;
          next_r.sq = blc_pkg::SQ_REQ;
        end else begin
          next_r.rsp_mabort = 1'b1;
        end
      end else begin
        next_r.rsp_retry = 1'b1;
      end
    end
    // Target-bus sequencer.
    case (r.sq)
      blc_pkg::SQ_REQ: begin
        if (s_req && s_gnt) begin
          next_r.sq = blc_pkg::SQ_ADDR;
          next_r.s_start = 1'b1;
        end
      end
      blc_pkg::SQ_ADDR: begin
        next_r.sq = blc_pkg::SQ_DATA;
        next_r.own_lock = 1'b1;
      end
      blc_pkg::SQ_DATA: begin
        if (s_done) begin
          next_r.sq = blc_pkg::SQ_IDLE;
          if (!r.q_write) begin
            next_r.rdata = s_rdata;
            next_r.dly_ready = 1'b1;
            next_r.dly_abort = blc_pkg::AB_NONE;
          end else if (r.rel_at_end) begin
            next_r.own_lock = 1'b0;
            next_r.st = blc_pkg::LK_REL;
          end
        end else if (s_retry) begin
          next_r.sq = blc_pkg::SQ_REQ;
          if (r.st == blc_pkg::LK_PEND) begin
            next_r.own_lock = 1'b0;
          end
        end else if (s_tabort || s_mabort) begin
          next_r.sq = blc_pkg::SQ_IDLE;
          if (r.q_write) begin
            next_r.serr = serr_enable && (s_tabort || master_abort_mode);
            set_ta = s_tabort;
            set_ma = !s_tabort;
            if (r.rel_at_end) begin
              next_r.own_lock = 1'b0;
              next_r.st = blc_pkg::LK_REL;
            end
          end else begin
            next_r.dly_ready = 1'b1;
            next_r.dly_abort = s_tabort ? blc_pkg::AB_TARGET : blc_pkg::AB_MASTER;
            if (r.st == blc_pkg::LK_PEND) begin
              next_r.own_lock = 1'b0;
            end
          end
        end
      end
      default: begin
      end
    endcase
    // Release once the initiator drops lock with frame idle.
    if (r.st == blc_pkg::LK_EST && p.lock_n && p.frame_n) begin
      if (r.sq == blc_pkg::SQ_IDLE) begin
        next_r.own_lock = 1'b0;
        next_r.dly_ready = 1'b0;
        next_r.st = blc_pkg::LK_REL;
      end else if (r.q_write) begin
        next_r.rel_at_end = 1'b1;
      end
    end
    // Releasing lasts one cycle, then unlocked forwarding resumes.
    if (r.st == blc_pkg::LK_REL) begin
      next_r.st = blc_pkg::LK_IDLE;
      next_r.rel_at_end = 1'b0;
    end
    // Master timeout discards the data and the queued request.
    if (r.st == blc_pkg::LK_PEND && r.dly_ready &&
        r.tmo == 16'(MTO_CYCLES - 1)) begin
      next_r.st = blc_pkg::LK_IDLE;
      next_r.dly_ready = 1'b0;
      next_r.own_lock = 1'b0;
      next_r.serr = serr_enable && mto_serr_enable;
    end
    // Sticky flags: a set in the clearing cycle wins.
    next_r.sse = (r.sse && !status_clear) || next_r.serr;
    next_r.rta = (r.rta && !status_clear) || set_ta;
    next_r.rma = (r.rma && !status_clear) || set_ma;
  end

  // State register; reset leaves the owner idle.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Request only when earlier work drained and the lock is free.
  assign s_req = r.sq == blc_pkg::SQ_REQ && q_empty && s_bus_idle && lock_free;
  assign s_start = r.s_start;
  assign s_cmd = r.q_cmd;
  assign s_addr = r.q_addr;
  assign s_be = r.q_be;
  assign s_wdata = r.q_wdata;
  assign s_lock_n_o = 1'b0;
  assign s_lock_oe_n = ~r.own_lock;
  assign primary_system_error_n = ~r.serr;
  assign signaled_system_error = r.sse;
  assign received_target_abort = r.rta;
  assign received_master_abort = r.rma;
  assign lock_state = r.st;
  assign p.trdy = r.rsp_trdy;
  assign p.retry = r.rsp_retry;
  assign p.tabort = r.rsp_tabort;
  assign p.mabort = r.rsp_mabort;
  assign p.rdata = r.rdata;
endmodule : blc_bridge
`default_nettype wire

// ---- logic/blc_initiator.sv ----
// Initiator end: runs single-data transactions, with or without the lock.
// Assumes the bridge end on the interface and a user issuing requests.
`timescale 1ns/100ps
`default_nettype none
`include "blc_cfg.svh"
module blc_initiator #(
  parameter int HOST_WAIT = `BLC_HOST_WAIT
) (
  input wire logic mclk,
  input wire logic resetn,
  blc_if.initiator p,
  input wire logic start, // Request pulse.
  input wire logic want_lock, // Use the lock sequence.
  input wire logic last, // Drop the lock after this transaction.
  input wire logic [3:0] cmd, // Command.
  input wire logic [`BLC_AW-1:0] addr, // Address.
  input wire logic [3:0] be, // Byte enables.
  input wire logic [`BLC_AW-1:0] wdata, // Write data.
  input wire logic downstream, // Target beyond the bridge.
  input wire logic bus_idle, // Primary bus idle.
  input wire logic other_lock_n, // Lock held by another master, low.
  output logic busy, // Transaction in progress.
  output logic done, // End pulse.
  output logic [1:0] result, // End code.
  output logic [`BLC_AW-1:0] rdata, // Read data.
  output logic lock_owned // Target counts as locked.
);
  blc_pkg::host_state_regs_t r; // Registered state.
  blc_pkg::host_state_regs_t next_r; // Next state.

  // Next-state logic for the initiator.
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.addr_valid = 1'b0;
    case (r.st)
      blc_pkg::HS_IDLE: begin
        if (start) begin
          next_r.cmd = cmd;
          next_r.addr = addr;
          next_r.be = be;
          next_r.wdata = wdata;
          next_r.down = downstream;
          next_r.is_lock = want_lock;
          next_r.is_last = last;
          next_r.st = blc_pkg::HS_CHECK;
        end
      end
      blc_pkg::HS_CHECK: begin
        // A fresh lock needs an idle bus and a free lock.
        if (bus_idle && (r.owned || !r.is_lock || other_lock_n)) begin
          next_r.st = blc_pkg::HS_ADDR;
          next_r.frame_n = 1'b0;
          next_r.addr_valid = 1'b1;
        end
      end
      blc_pkg::HS_ADDR: begin
        // Lock goes low one cycle after the address phase.
        if (r.is_lock) begin
          next_r.lock_n = 1'b0;
        end
        next_r.wait_cnt = 4'h0;
        next_r.st = blc_pkg::HS_DATA;
      end
      default: begin
        next_r.wait_cnt = r.wait_cnt + 4'h1;
        if (p.trdy || p.retry || p.tabort || p.mabort ||
            r.wait_cnt == 4'(HOST_WAIT - 1)) begin
          next_r.st = blc_pkg::HS_IDLE;
          next_r.frame_n = 1'b1;
          next_r.done = 1'b1;
          if (p.trdy) begin
            next_r.result = `BLC_RES_OK;
            next_r.rdata = p.rdata;
            next_r.owned = r.is_lock && !r.is_last;
            if (r.is_last || !r.is_lock) begin
              next_r.lock_n = 1'b1;
            end
          end else if (p.retry) begin
            next_r.result = `BLC_RES_RETRY;
            if (!r.owned) begin
              next_r.lock_n = 1'b1;
            end
          end else begin
            // Abort, or no claim at all, ends the lock.
            next_r.result = p.tabort ? `BLC_RES_TABORT : `BLC_RES_MABORT;
            next_r.lock_n = 1'b1;
            next_r.owned = 1'b0;
          end
        end
      end
    endcase
  end

  // State register; frame and lock lines idle high after reset.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.frame_n <= 1'b1;
      r.lock_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign p.frame_n = r.frame_n;
  assign p.lock_n = r.lock_n;
  assign p.addr_valid = r.addr_valid;
  assign p.cmd = r.cmd;
  assign p.addr = r.addr;
  assign p.be = r.be;
  assign p.wdata = r.wdata;
  assign p.downstream = r.down;
  assign busy = r.st != blc_pkg::HS_IDLE;
  assign done = r.done;
  assign result = r.result;
  assign rdata = r.rdata;
  assign lock_owned = r.owned;
endmodule : blc_initiator
`default_nettype wire

// ---- verification/blc_properties.sv ----
// Checker for the primary-bus handshake between the initiator end and the bridge end.
// Assumes it sits beside the interface and shares the single mclk domain.
`timescale 1ns/100ps
`default_nettype none
`include "blc_cfg.svh"
module blc_checker (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic frame_n,
  input wire logic lock_n,
  input wire logic addr_valid,
  input wire logic [3:0] cmd,
  input wire logic downstream,
  input wire logic trdy,
  input wire logic retry,
  input wire logic tabort,
  input wire logic mabort,
  input wire logic [`BLC_AW-1:0] rdata
);
  // Any of the four target answers.
  logic resp;
  assign resp = trdy | retry | tabort | mabort;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Opening of a lock with a command other than a memory read.
  sequence s_open_nonread;
    addr_valid && downstream && lock_n && cmd != `BLC_CMD_MEM_RD ##1 !lock_n;
  endsequence
  property p_open_nonread;
    s_open_nonread |-> ##1 (mabort || retry);
  endproperty
  a_open_nonread: assert property (p_open_nonread)
    else $error("Non-read lock opening was accepted.");
  property p_lock_after_addr;
    $fell(lock_n) |-> $past(addr_valid);
  endproperty
  a_lock_after_addr: assert property (p_lock_after_addr)
    else $error("Lock asserted without a preceding address phase.");
  property p_addr_frame;
    addr_valid |-> $fell(frame_n);
  endproperty
  a_addr_frame: assert property (p_addr_frame)
    else $error("Address phase not at the start of a frame.");
  property p_resp_timing;
    resp |-> $past(addr_valid, 2);
  endproperty
  a_resp_timing: assert property (p_resp_timing)
    else $error("Answer not two cycles after the address phase.");
  property p_upstream;
    addr_valid && !downstream |-> ##2 !resp;
  endproperty
  a_upstream: assert property (p_upstream)
    else $error("Bridge answered a transaction that does not cross it.");
  property p_resp_onehot;
    $onehot0({trdy, retry, tabort, mabort});
  endproperty
  a_resp_onehot: assert property (p_resp_onehot)
    else $error("More than one answer at once.");
  property p_resp_in_frame;
    resp |-> !frame_n;
  endproperty
  a_resp_in_frame: assert property (p_resp_in_frame)
    else $error("Answer outside a frame.");
  property p_frame_ends;
    resp |=> frame_n;
  endproperty
  a_frame_ends: assert property (p_frame_ends)
    else $error("Frame not closed after the answer.");
  // Read data is captured from the target bus early and must stand through its answer.
  property p_rdata_hold;
    trdy |-> $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("Read data changed in the cycle of its data transfer.");
endmodule : blc_checker
`default_nettype wire

// ---- verification/tb_top.sv ----
// Testbench joining the initiator end and the bridge end, with a simple target bus.
// Assumes the design files and blc_cfg.svh are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "blc_cfg.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  localparam logic [3:0] RD = `BLC_CMD_MEM_RD;
  localparam logic [3:0] WR = `BLC_CMD_MEM_WR;
  logic mclk = 0, resetn = 0, start = 0, want_lock = 0, last = 0, downstream = 1;
  logic bus_idle = 1, other_lock_n = 1, q_empty = 1, s_bus_idle = 1, status_clear = 0;
  logic s_done = 0, s_retry = 0, s_tabort = 0, s_mabort = 0, foreign_n = 1, serr_seen = 0;
  logic serr_enable = 1, master_abort_mode = 1, mto_serr_enable = 1;
  logic [3:0] cmd = 4'h0, be = 4'hf, s_cmd, s_be;
  logic [`BLC_AW-1:0] addr = 32'h0000_1000, wdata = 32'h1234_5678, rdata, s_rdata;
  logic [`BLC_AW-1:0] s_addr, s_wdata;
  logic busy, done, lock_owned, s_req, s_gnt, s_start, s_lock_n_o, s_lock_oe_n, s_lock_n_i;
  logic primary_system_error_n, signaled_system_error;
  logic received_target_abort, received_master_abort;
  logic [1:0] result, tgt_mode = 2'h0;
  logic [3:0] bad_cmd [5] = '{4'ha, 4'hb, 4'h2, 4'h3, 4'h7};
  blc_pkg::lock_state_t lock_state;
  int n_errors = 0, samples_checked = 0, cnt = 0;
  // Clock of 100 ns period.
  always #50 mclk = ~mclk;
  // Target bus: grant follows request, data answers from the address.
  assign s_gnt = s_req;
  assign s_rdata = s_addr ^ 32'hffff_0000;
  // Lock wire level from the bridge drive and another target-bus master.
  assign s_lock_n_i = s_lock_oe_n ? foreign_n : s_lock_n_o;
  blc_if blc_if_inst ();
  blc_initiator #(.HOST_WAIT(8)) blc_initiator_inst (.mclk, .resetn, .p(blc_if_inst),
    .start, .want_lock, .last, .cmd, .addr, .be, .wdata, .downstream, .bus_idle,
    .other_lock_n, .busy, .done, .result, .rdata, .lock_owned);
  blc_bridge #(.MTO_CYCLES(16)) blc_bridge_inst (.mclk, .resetn, .p(blc_if_inst), .q_empty,
    .s_bus_idle, .s_gnt, .s_lock_n_i, .s_done, .s_retry, .s_tabort, .s_mabort, .s_rdata,
    .serr_enable, .master_abort_mode, .mto_serr_enable, .status_clear, .s_req, .s_start,
    .s_cmd, .s_addr, .s_be, .s_wdata, .s_lock_n_o, .s_lock_oe_n, .primary_system_error_n,
    .signaled_system_error, .received_target_abort, .received_master_abort, .lock_state);
  blc_checker blc_checker_inst (.mclk, .resetn, .frame_n(blc_if_inst.frame_n),
    .lock_n(blc_if_inst.lock_n), .addr_valid(blc_if_inst.addr_valid),
    .cmd(blc_if_inst.cmd), .downstream(blc_if_inst.downstream), .trdy(blc_if_inst.trdy),
    .retry(blc_if_inst.retry), .tabort(blc_if_inst.tabort), .mabort(blc_if_inst.mabort),
    .rdata(blc_if_inst.rdata));
  // Target responder ends each data phase two cycles after the start.
  always @(negedge mclk) begin
    {s_retry, s_mabort, s_tabort, s_done} <= 4'h0;
    if (!primary_system_error_n) serr_seen <= 1'b1;
    if (s_start) cnt <= 2;
    else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) {s_retry, s_mabort, s_tabort, s_done} <= 4'h1 << tgt_mode;
    end
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  // Runs one transaction and compares its end code.
  task automatic txn(input logic lk, input logic ls, input logic [3:0] c, input logic dn,
    input logic [1:0] exp);
    int i;
    want_lock = lk;
    last = ls;
    cmd = c;
    downstream = dn;
    start = 1;
    @(negedge mclk);
    start = 0;
    // While another master holds the lock, no locked frame may open.
    if (!other_lock_n) begin
      cyc(6);
      `CHK(busy, 1'b1)
      `CHK(blc_if_inst.frame_n, 1'b1)
      other_lock_n = 1;
    end
    for (i = 0; i < 40 && done !== 1'b1; i++) @(negedge mclk);
    if (i == 40) begin
      n_errors++;
      stop_test();
    end
    `CHK(result, exp)
  endtask : txn
  // Main sequence.
  initial begin
    cyc(2);
    resetn = 1;
    `CHK(lock_state, blc_pkg::LK_IDLE)
    txn(1, 0, RD, 1, `BLC_RES_RETRY);
    `CHK(lock_state, blc_pkg::LK_PEND)
    txn(0, 0, WR, 1, `BLC_RES_RETRY);
    cyc(8);
    `CHK(s_lock_oe_n, 1'b0)
    txn(1, 0, RD, 1, `BLC_RES_OK);
    `CHK(rdata, addr ^ 32'hffff_0000)
    `CHK(lock_owned, 1'b1)
    `CHK(lock_state, blc_pkg::LK_EST)
    tgt_mode = 2'h2;
    txn(1, 0, WR, 1, `BLC_RES_OK);
    cyc(8);
    `CHK(serr_seen, 1'b1)
    `CHK(received_master_abort, 1'b1)
    `CHK(signaled_system_error, 1'b1)
    `CHK(s_lock_oe_n, 1'b0)
    `CHK(s_wdata, wdata)
    `CHK(s_addr, addr)
    `CHK(s_be, be)
    tgt_mode = 2'h0;
    txn(1, 1, WR, 1, `BLC_RES_OK);
    cyc(8);
    `CHK(s_cmd, WR)
    `CHK(s_lock_oe_n, 1'b1)
    `CHK(lock_state, blc_pkg::LK_IDLE)
    addr = 32'h0000_2040;
    q_empty = 0;
    txn(1, 0, RD, 1, `BLC_RES_RETRY);
    cyc(4);
    // Earlier queued work has not drained, so the locked read must not launch yet.
    `CHK(s_lock_oe_n, 1'b1)
    `CHK(lock_state, blc_pkg::LK_PEND)
    q_empty = 1;
    cyc(8);
    txn(1, 1, RD, 1, `BLC_RES_OK);
    `CHK(rdata, addr ^ 32'hffff_0000)
    cyc(4);
    `CHK(s_lock_oe_n, 1'b1)
    `CHK(lock_state, blc_pkg::LK_IDLE)
    foreach (bad_cmd[i]) begin
      txn(1, 1, bad_cmd[i], 1, `BLC_RES_MABORT);
      `CHK(lock_state, blc_pkg::LK_IDLE)
    end
    foreign_n = 0;
    other_lock_n = 0;
    txn(1, 1, RD, 1, `BLC_RES_RETRY);
    `CHK(lock_state, blc_pkg::LK_IDLE)
    foreign_n = 1;
    tgt_mode = 2'h1;
    txn(1, 0, RD, 1, `BLC_RES_RETRY);
    cyc(8);
    txn(1, 1, RD, 1, `BLC_RES_TABORT);
    `CHK(received_target_abort, 1'b1)
    `CHK(lock_state, blc_pkg::LK_IDLE)
    tgt_mode = 2'h0;
    addr = 32'h0000_3000;
    serr_seen = 0;
    txn(1, 0, RD, 1, `BLC_RES_RETRY);
    cyc(40);
    `CHK(serr_seen, 1'b1)
    `CHK(s_lock_oe_n, 1'b1)
    `CHK(lock_state, blc_pkg::LK_IDLE)
    txn(1, 1, RD, 0, `BLC_RES_MABORT);
    `CHK(lock_state, blc_pkg::LK_IDLE)
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
